// ===== src/ocp_telemetry_consts.svh
`ifndef OCP_TELEMETRY_CONSTS_SVH
`define OCP_TELEMETRY_CONSTS_SVH

`define NUM_RAILS 2
`define NUM_LANES 9

`define CMD_LINK_SCALE 8'hE3
`define CMD_LANE_AMPS 8'hE4
`define CMD_LANE_TEMP 8'hE5
`define CMD_PEAK_COUNTS 8'hE9
`define CMD_SLOW_THRESHOLD 8'hEA
`define CMD_FAST_FILTER 8'hEB

`define RST_LINK_SCALE 16'h4000
`define RST_PEAK_COUNTS 16'h0606
`define RST_SLOW_THRESHOLD 16'h00C8
`define RST_FAST_FILTER 16'h0696

`define SCALE_UNITY 16'h4000
`define SCALE_FRAC_BITS 14
`define PEAK_OC_MSB 7
`define PEAK_OC_LSB 0
`define PEAK_UC_MSB 15
`define PEAK_UC_LSB 8
`define FILT_SHIFT_MSB 11
`define FILT_SHIFT_LSB 8
`define DELAY_MSB 7
`define DELAY_LSB 0
`define FILTER_USED_MASK 16'h0FFF
`define RUN_MAX 8'hFF

`define CAUSE_PEAK_OC 0
`define CAUSE_PEAK_UC 1
`define CAUSE_SLOW 2
`define CAUSE_FAST 3

// times in picoseconds, figures as specified
`define CLK_PERIOD_PS 32'd100000
`define FILT_TAU_UNIT_PS 32'd166700
`define FAST_DELAY_UNIT_PS 32'd667000
`define SLOW_DELAY_UNIT_PS 32'd170700000

`endif

// ===== src/ocp_telemetry_pkg.sv
package ocp_telemetry_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic signed [15:0] amps_t;
  typedef logic signed [31:0] filt_acc_t;
  typedef logic [7:0] run_count_t;
  typedef logic [3:0] fault_cause_t;
endpackage

// ===== src/overcurrent_fault_telemetry_regs.sv
`timescale 1ns/1ps
`include "ocp_telemetry_consts.svh"

module overcurrent_fault_telemetry_regs (
  input wire logic clk_in,                                  // 10 MHz clock
  input wire logic nrst_in,                                 // synchronous reset, active low
  input wire logic en_in,                                   // clock enable, freezes all state
  input wire logic [7:0] cmd_code_in,                       // management command code
  input wire logic page_in,                                 // selected rail for paged commands
  input wire logic wr_req_in,                               // write strobe
  input wire logic [15:0] wr_data_in,                       // write word
  input wire logic rd_req_in,                               // read strobe
  output logic [15:0] rd_data_out,                          // read word
  output logic rd_valid_out,                                // read answer pulse
  output logic cmd_unsup_out,                               // unmapped command pulse
  input wire logic [3:0] lane_sel_in,                       // lane chosen by phase select
  input wire logic [`NUM_LANES*16-1:0] lane_amps_in,        // per-lane current, 0.1A lsb
  input wire logic [`NUM_LANES*16-1:0] lane_temp_in,        // per-lane temperature, 1 C lsb
  input wire logic [`NUM_LANES-1:0] lane_rail_in,           // lane to rail map, 1 = rail 1
  input wire logic [`NUM_LANES-1:0] cycle_end_in,           // switching cycle end pulse
  input wire logic [`NUM_LANES-1:0] peak_oc_hit_in,         // cycle exceeded peak overcurrent
  input wire logic [`NUM_LANES-1:0] peak_uc_hit_in,         // cycle exceeded peak undercurrent
  input wire logic [`NUM_RAILS*16-1:0] sum_amps_in,         // rail sum current, 0.1A lsb
  input wire logic [`NUM_RAILS*16-1:0] fast_limit_in,       // fast path threshold, 0.1A lsb
  input wire logic [`NUM_RAILS*16-1:0] slow_filter_cfg_in,  // slow filter and delay setting
  input wire logic fault_clear_in,                          // clears latched fault causes
  output logic [`NUM_RAILS*16-1:0] link_amps_out,           // scaled current for fast link
  output logic [`NUM_LANES-1:0] cc_limit_out,               // lane limiting without shutdown
  output logic [`NUM_RAILS*4-1:0] fault_cause_out,          // latched causes per rail
  output logic [`NUM_RAILS-1:0] rail_fault_out              // rail fault level
);

  ocp_telemetry_pkg::reg_word_t link_scale [`NUM_RAILS];
  ocp_telemetry_pkg::reg_word_t peak_counts [`NUM_RAILS];
  ocp_telemetry_pkg::reg_word_t slow_threshold [`NUM_RAILS];
  ocp_telemetry_pkg::reg_word_t fast_filter [`NUM_RAILS];
  ocp_telemetry_pkg::fault_cause_t cause [`NUM_RAILS];
  ocp_telemetry_pkg::run_count_t oc_run [`NUM_LANES];
  ocp_telemetry_pkg::run_count_t uc_run [`NUM_LANES];
  logic [`NUM_RAILS-1:0] peak_oc_set;
  logic [`NUM_RAILS-1:0] peak_uc_set;
  logic [`NUM_RAILS-1:0] slow_set;
  logic [`NUM_RAILS-1:0] fast_set;
  logic [31:0] tau_acc;
  logic tau_tick;
  logic [31:0] next_tau_acc;
  logic [15:0] next_rd_data;
  logic next_unsup;

  // filter time base: one tick per 166.7ns, phase carried so the average rate is exact
  always_comb
  begin
    next_tau_acc = tau_acc + `CLK_PERIOD_PS;
    tau_tick = 1'b0;
    if (next_tau_acc >= `FILT_TAU_UNIT_PS)
    begin
      next_tau_acc = next_tau_acc - `FILT_TAU_UNIT_PS;
      tau_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      tau_acc <= 32'h0;
    else if (en_in)
      tau_acc <= next_tau_acc;
  end

  // paged register writes; read-only lane commands take no write
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      for (int r = 0; r < `NUM_RAILS; r++)
      begin
        link_scale[r] <= `RST_LINK_SCALE;
        peak_counts[r] <= `RST_PEAK_COUNTS;
        slow_threshold[r] <= `RST_SLOW_THRESHOLD;
        fast_filter[r] <= `RST_FAST_FILTER;
      end
    end
    else if (en_in && wr_req_in)
    begin
      unique case (cmd_code_in)
        `CMD_LINK_SCALE: link_scale[page_in] <= wr_data_in;
        `CMD_PEAK_COUNTS: peak_counts[page_in] <= wr_data_in;
        `CMD_SLOW_THRESHOLD: slow_threshold[page_in] <= wr_data_in;
        `CMD_FAST_FILTER: fast_filter[page_in] <= wr_data_in & `FILTER_USED_MASK;
        default: ;
      endcase
    end
  end

  // read mux; out-of-range lane reads as zero
  always_comb
  begin
    next_rd_data = 16'h0000;
    next_unsup = 1'b0;
    unique case (cmd_code_in)
      `CMD_LINK_SCALE: next_rd_data = link_scale[page_in];
      `CMD_LANE_AMPS:
      begin
        if (lane_sel_in < 4'(`NUM_LANES))
          next_rd_data = lane_amps_in[lane_sel_in*16 +: 16];
      end
      `CMD_LANE_TEMP:
      begin
        if (lane_sel_in < 4'(`NUM_LANES))
          next_rd_data = lane_temp_in[lane_sel_in*16 +: 16];
      end
      `CMD_PEAK_COUNTS: next_rd_data = peak_counts[page_in];
      `CMD_SLOW_THRESHOLD: next_rd_data = slow_threshold[page_in];
      `CMD_FAST_FILTER: next_rd_data = fast_filter[page_in];
      default: next_unsup = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
      cmd_unsup_out <= 1'b0;
    end
    else if (en_in)
    begin
      rd_valid_out <= rd_req_in;
      cmd_unsup_out <= (rd_req_in || wr_req_in) && next_unsup;
      if (rd_req_in)
        rd_data_out <= next_rd_data;
    end
  end

  // per-lane consecutive peak runs
  for (genvar l = 0; l < `NUM_LANES; l++)
  begin : g_lane
    logic [7:0] oc_limit;
    logic [7:0] uc_limit;
    assign oc_limit = peak_counts[lane_rail_in[l]][`PEAK_OC_MSB:`PEAK_OC_LSB];
    assign uc_limit = peak_counts[lane_rail_in[l]][`PEAK_UC_MSB:`PEAK_UC_LSB];

    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
      begin
        oc_run[l] <= 8'h00;
        uc_run[l] <= 8'h00;
        cc_limit_out[l] <= 1'b0;
      end
      else if (en_in && cycle_end_in[l])
      begin
        // runs saturate so a long event never wraps back under the limit
        if (!peak_oc_hit_in[l])
          oc_run[l] <= 8'h00;
        else if (oc_run[l] != `RUN_MAX)
          oc_run[l] <= oc_run[l] + 8'h01;
        if (!peak_uc_hit_in[l])
          uc_run[l] <= 8'h00;
        else if (uc_run[l] != `RUN_MAX)
          uc_run[l] <= uc_run[l] + 8'h01;
        cc_limit_out[l] <= (peak_oc_hit_in[l] && oc_limit == 8'h00)
                           || (peak_uc_hit_in[l] && uc_limit == 8'h00);
      end
    end
  end

  // a fault fires on the cycle end whose event completes the run
  always_comb
  begin
    peak_oc_set = '0;
    peak_uc_set = '0;
    for (int l = 0; l < `NUM_LANES; l++)
    begin
      if (en_in && cycle_end_in[l] && peak_oc_hit_in[l]
          && peak_counts[lane_rail_in[l]][`PEAK_OC_MSB:`PEAK_OC_LSB] != 8'h00
          && 9'(oc_run[l]) + 9'h001 >= 9'(peak_counts[lane_rail_in[l]][`PEAK_OC_MSB:`PEAK_OC_LSB]))
        peak_oc_set[lane_rail_in[l]] = 1'b1;
      if (en_in && cycle_end_in[l] && peak_uc_hit_in[l]
          && peak_counts[lane_rail_in[l]][`PEAK_UC_MSB:`PEAK_UC_LSB] != 8'h00
          && 9'(uc_run[l]) + 9'h001 >= 9'(peak_counts[lane_rail_in[l]][`PEAK_UC_MSB:`PEAK_UC_LSB]))
        peak_uc_set[lane_rail_in[l]] = 1'b1;
    end
  end

  for (genvar r = 0; r < `NUM_RAILS; r++)
  begin : g_rail
    ocp_telemetry_pkg::amps_t sum_now;
    ocp_telemetry_pkg::filt_acc_t fast_acc;
    ocp_telemetry_pkg::filt_acc_t slow_acc;
    logic [32:0] fast_diff;
    logic [32:0] slow_diff;
    logic [32:0] fast_step;
    logic [32:0] slow_step;
    logic fast_over;
    logic slow_over;
    logic [31:0] fast_unit_acc;
    logic [31:0] slow_unit_acc;
    logic [7:0] fast_elapsed;
    logic [7:0] slow_elapsed;
    logic [16:0] scale_eff;
    logic signed [33:0] product;

    assign sum_now = sum_amps_in[r*16 +: 16];

    // fixed-point report scaling, saturated so a 4x scale cannot wrap the sign
    assign scale_eff = (link_scale[r] == 16'h0000) ? {1'b0, `SCALE_UNITY} : {1'b0, link_scale[r]};
    assign product = 34'(sum_now) * $signed({1'b0, scale_eff});

    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
        link_amps_out[r*16 +: 16] <= 16'h0000;
      else if (en_in)
      begin
        if (product[33:`SCALE_FRAC_BITS+15] != {(34-`SCALE_FRAC_BITS-15){product[33]}})
          link_amps_out[r*16 +: 16] <= product[33] ? 16'h8000 : 16'h7FFF;
        else
          link_amps_out[r*16 +: 16] <= product[`SCALE_FRAC_BITS+15:`SCALE_FRAC_BITS];
      end
    end

    // first-order filters, alpha = 2^-shift at each 166.7ns tick
    assign fast_diff = {sum_now[15], sum_now, 16'h0000} - {fast_acc[31], fast_acc};
    assign slow_diff = {sum_now[15], sum_now, 16'h0000} - {slow_acc[31], slow_acc};
    assign fast_step = $signed(fast_diff) >>> fast_filter[r][`FILT_SHIFT_MSB:`FILT_SHIFT_LSB];
    assign slow_step = $signed(slow_diff) >>> slow_filter_cfg_in[r*16+`FILT_SHIFT_LSB +: 4];

    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
      begin
        fast_acc <= 32'h0;
        slow_acc <= 32'h0;
      end
      else if (en_in && tau_tick)
      begin
        fast_acc <= fast_acc + fast_step[31:0];
        slow_acc <= slow_acc + slow_step[31:0];
      end
    end

    assign fast_over = $signed(fast_acc[31:16]) > $signed(fast_limit_in[r*16 +: 16]);
    assign slow_over = (slow_threshold[r] != 16'h0000)
                       && $signed(slow_acc[31:16]) > $signed(slow_threshold[r]);

    // delay timers: whole units elapsed while over, cleared on any drop
    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
      begin
        fast_unit_acc <= 32'h0;
        fast_elapsed <= 8'h00;
      end
      else if (en_in)
      begin
        if (!fast_over)
        begin
          fast_unit_acc <= 32'h0;
          fast_elapsed <= 8'h00;
        end
        else if (fast_elapsed < fast_filter[r][`DELAY_MSB:`DELAY_LSB])
        begin
          if (fast_unit_acc + `CLK_PERIOD_PS >= `FAST_DELAY_UNIT_PS)
          begin
            fast_unit_acc <= fast_unit_acc + `CLK_PERIOD_PS - `FAST_DELAY_UNIT_PS;
            fast_elapsed <= fast_elapsed + 8'h01;
          end
          else
            fast_unit_acc <= fast_unit_acc + `CLK_PERIOD_PS;
        end
      end
    end

    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
      begin
        slow_unit_acc <= 32'h0;
        slow_elapsed <= 8'h00;
      end
      else if (en_in)
      begin
        if (!slow_over)
        begin
          slow_unit_acc <= 32'h0;
          slow_elapsed <= 8'h00;
        end
        else if (slow_elapsed < slow_filter_cfg_in[r*16+`DELAY_LSB +: 8])
        begin
          if (slow_unit_acc + `CLK_PERIOD_PS >= `SLOW_DELAY_UNIT_PS)
          begin
            slow_unit_acc <= slow_unit_acc + `CLK_PERIOD_PS - `SLOW_DELAY_UNIT_PS;
            slow_elapsed <= slow_elapsed + 8'h01;
          end
          else
            slow_unit_acc <= slow_unit_acc + `CLK_PERIOD_PS;
        end
      end
    end

    // zero delay faults on the first over cycle
    assign fast_set[r] = en_in && fast_over && fast_elapsed >= fast_filter[r][`DELAY_MSB:`DELAY_LSB];
    assign slow_set[r] = en_in && slow_over && slow_elapsed >= slow_filter_cfg_in[r*16+`DELAY_LSB +: 8];

    // latched causes; a new event in the clearing cycle stays latched
    always_ff @(posedge clk_in)
    begin
      if (!nrst_in)
        cause[r] <= 4'h0;
      else if (en_in)
      begin
        cause[r][`CAUSE_PEAK_OC] <= peak_oc_set[r] || (cause[r][`CAUSE_PEAK_OC] && !fault_clear_in);
        cause[r][`CAUSE_PEAK_UC] <= peak_uc_set[r] || (cause[r][`CAUSE_PEAK_UC] && !fault_clear_in);
        cause[r][`CAUSE_SLOW] <= slow_set[r] || (cause[r][`CAUSE_SLOW] && !fault_clear_in);
        cause[r][`CAUSE_FAST] <= fast_set[r] || (cause[r][`CAUSE_FAST] && !fault_clear_in);
      end
    end

    assign fault_cause_out[r*4 +: 4] = cause[r];
    assign rail_fault_out[r] = |cause[r];
  end

endmodule

// ===== dv/ocp_telemetry_checker.sv
`timescale 1ns/1ps
`include "ocp_telemetry_consts.svh"
module ocp_telemetry_checker (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // reset
  input wire logic en_in, // enable
  input wire logic [7:0] cmd_code_in, // command
  input wire logic wr_req_in, // write
  input wire logic rd_req_in, // read
  input wire logic [15:0] rd_data_out, // read word
  input wire logic rd_valid_out, // read pulse
  input wire logic cmd_unsup_out, // unmapped pulse
  input wire logic [3:0] lane_sel_in, // lane
  input wire logic [`NUM_LANES*16-1:0] lane_amps_in, // currents
  input wire logic [`NUM_LANES*16-1:0] lane_temp_in, // temperatures
  input wire logic fault_clear_in, // clear
  input wire logic [`NUM_RAILS*4-1:0] fault_cause_out, // causes
  input wire logic [`NUM_RAILS-1:0] rail_fault_out // rail faults
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic mapped;
  logic rd_go;
  logic any_go;
  assign mapped = cmd_code_in inside {8'hE3, 8'hE4, 8'hE5, 8'hE9, 8'hEA, 8'hEB};
  assign rd_go = rd_req_in && en_in;
  assign any_go = rd_go || (wr_req_in && en_in);
  a_read_answered: assert property (rd_go |=> rd_valid_out)
    else $error("read not answered");
  a_answer_has_cause: assert property (rd_valid_out && $past(en_in) |-> $past(rd_go))
    else $error("read answer without request");
  a_unmapped_flagged: assert property (any_go |=> cmd_unsup_out == !$past(mapped))
    else $error("unmapped flag wrong");
  a_unmapped_reads_zero: assert property (rd_go && !mapped |=> rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  a_lane_amps_read: assert property (rd_go && cmd_code_in == `CMD_LANE_AMPS && lane_sel_in < 4'h9
    |=> rd_data_out == $past(lane_amps_in[lane_sel_in*16 +: 16]))
    else $error("lane current read wrong");
  a_lane_temp_read: assert property (rd_go && cmd_code_in == `CMD_LANE_TEMP && lane_sel_in < 4'h9
    |=> rd_data_out == $past(lane_temp_in[lane_sel_in*16 +: 16]))
    else $error("lane temperature read wrong");
  a_cause_sticky: assert property (fault_cause_out[0] && !fault_clear_in |=> fault_cause_out[0])
    else $error("peak cause dropped");
  a_rail_fault_or: assert property (rail_fault_out == {|fault_cause_out[7:4], |fault_cause_out[3:0]})
    else $error("rail fault not causes");
  cover property (rd_go && cmd_code_in == `CMD_LANE_AMPS);
  cover property ($rose(rail_fault_out[0]));
  cover property (cmd_unsup_out);
endmodule

bind overcurrent_fault_telemetry_regs ocp_telemetry_checker chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .en_in(en_in), .cmd_code_in(cmd_code_in),
  .wr_req_in(wr_req_in), .rd_req_in(rd_req_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .cmd_unsup_out(cmd_unsup_out), .lane_sel_in(lane_sel_in),
  .lane_amps_in(lane_amps_in), .lane_temp_in(lane_temp_in), .fault_clear_in(fault_clear_in),
  .fault_cause_out(fault_cause_out), .rail_fault_out(rail_fault_out)
);

// ===== dv/mgmt_host_model.sv
`timescale 1ns/1ps
module mgmt_host_model (
  input wire logic clk_in, // clock
  input wire logic [15:0] rdata_in, // read word
  input wire logic rvalid_in, // read answer
  output logic [7:0] cmd_out, // command
  output logic page_out, // rail
  output logic wr_out, // write strobe
  output logic [15:0] data_out, // write word
  output logic rd_out // read strobe
);
  initial
  begin
    cmd_out = 8'h00;
    page_out = 1'b0;
    wr_out = 1'b0;
    data_out = 16'h0000;
    rd_out = 1'b0;
  end
  task automatic write_word(input logic [7:0] c, input logic p, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    cmd_out = c;
    page_out = p;
    data_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
  endtask
  // bounded wait: a missing answer returns unknown so the caller's compare fails
  task automatic read_word(input logic [7:0] c, input logic p, output logic [15:0] d);
    int n;
    @(posedge clk_in);
    #1;
    cmd_out = c;
    page_out = p;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    n = 0;
    while (rvalid_in !== 1'b1 && n < 8)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
  endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "ocp_telemetry_consts.svh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  logic fclr = 1'b0;
  logic page, wr, rd, rv, unsup;
  logic [7:0] cmd;
  logic [15:0] wd, rdat, got;
  logic [3:0] lsel = 4'h0;
  logic [`NUM_LANES*16-1:0] lamps = '0, ltemp = '0;
  logic [`NUM_LANES-1:0] lrail = '0, cend = '0, ochit = '0, uchit = '0, ccl;
  logic [`NUM_RAILS*16-1:0] sums = '0, flim = {2{16'h7FFF}}, scfg = '0, link;
  logic [7:0] cause;
  logic [1:0] rfault;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  mgmt_host_model host (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .cmd_out(cmd),
    .page_out(page), .wr_out(wr), .data_out(wd), .rd_out(rd));
  overcurrent_fault_telemetry_regs uut (.clk_in(clk), .nrst_in(nrst), .en_in(en), .cmd_code_in(cmd),
    .page_in(page), .wr_req_in(wr), .wr_data_in(wd), .rd_req_in(rd), .rd_data_out(rdat),
    .rd_valid_out(rv), .cmd_unsup_out(unsup), .lane_sel_in(lsel), .lane_amps_in(lamps),
    .lane_temp_in(ltemp), .lane_rail_in(lrail), .cycle_end_in(cend), .peak_oc_hit_in(ochit),
    .peak_uc_hit_in(uchit), .sum_amps_in(sums), .fast_limit_in(flim), .slow_filter_cfg_in(scfg),
    .fault_clear_in(fclr), .link_amps_out(link), .cc_limit_out(ccl), .fault_cause_out(cause),
    .rail_fault_out(rfault));
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] act);
    tests_run++;
    if (act !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_cycle(logic oc, logic uc);
    cend[0] = 1'b1;
    ochit[0] = oc;
    uchit[0] = uc;
    tick(1);
    cend[0] = 1'b0;
    tick(1);
  endtask
  task automatic clear_faults();
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    tick(1);
  endtask
  task automatic t_resets();
    logic [7:0] c[4] = '{8'hE3, 8'hE9, 8'hEA, 8'hEB};
    logic [15:0] v[4] = '{16'h4000, 16'h0606, 16'h00C8, 16'h0696};
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
      begin
        host.read_word(c[i], p[0], got);
        check("reset value", v[i], got);
      end
    host.read_word(8'h00, 1'b0, got);
    check("unmapped read", 16'h0000, got);
    check("unmapped flag", 16'h0001, {15'h0000, unsup});
  endtask
  task automatic t_write_back();
    host.write_word(8'hEB, 1'b1, 16'hF234);
    host.read_word(8'hEB, 1'b1, got);
    check("filter unused bits", 16'h0234, got);
    host.read_word(8'hEB, 1'b0, got);
    check("other rail filter", 16'h0696, got);
    lamps[15:0] = 16'h1234;
    host.write_word(8'hE4, 1'b0, 16'h5555);
    check("read-only write flag", 16'h0000, {15'h0000, unsup});
    host.read_word(8'hE4, 1'b0, got);
    check("lane current after write", 16'h1234, got);
    host.write_word(8'h00, 1'b0, 16'h5555);
    check("unmapped write flag", 16'h0001, {15'h0000, unsup});
    // a strobe while the enable is low must not reach the register
    tick(1);
    en = 1'b0;
    host.write_word(8'hE3, 1'b1, 16'h1111);
    en = 1'b1;
    host.read_word(8'hE3, 1'b1, got);
    check("write while disabled", 16'h4000, got);
  endtask
  task automatic t_lanes();
    for (int l = 0; l < 9; l++)
    begin
      lamps[l*16 +: 16] = 16'h8000 + 16'(l);
      ltemp[l*16 +: 16] = 16'hFFF6 - 16'(l);
    end
    for (int l = 0; l < 9; l++)
    begin
      lsel = 4'(l);
      host.read_word(8'hE4, 1'b0, got);
      check("lane current", 16'h8000 + 16'(l), got);
      host.read_word(8'hE5, 1'b0, got);
      check("lane temperature", 16'hFFF6 - 16'(l), got);
    end
  endtask
  task automatic t_scale();
    logic [15:0] s[3] = '{16'h2000, 16'h0000, 16'h8000};
    logic [15:0] e[3] = '{16'h0032, 16'h0064, 16'h00C8};
    sums[15:0] = 16'h0064;
    tick(3);
    check("link at unity", 16'h0064, link[15:0]);
    for (int i = 0; i < 3; i++)
    begin
      host.write_word(8'hE3, 1'b0, s[i]);
      tick(3);
      check("scaled link", e[i], link[15:0]);
    end
    sums = '0;
  endtask
  task automatic t_peak();
    host.write_word(8'hE9, 1'b0, 16'h0203);
    repeat (2) pulse_cycle(1'b1, 1'b0);
    pulse_cycle(1'b0, 1'b0);
    repeat (2) pulse_cycle(1'b1, 1'b0);
    check("broken run", 16'h0000, {12'h000, cause[3:0]});
    pulse_cycle(1'b1, 1'b0);
    check("overcurrent run", 16'h0003, {14'h0000, rfault[0], cause[0]});
    clear_faults();
    pulse_cycle(1'b0, 1'b1);
    check("short undercurrent run", 16'h0000, {12'h000, cause[3:0]});
    pulse_cycle(1'b0, 1'b1);
    check("undercurrent run", 16'h0002, {12'h000, cause[3:0]});
    clear_faults();
    host.write_word(8'hE9, 1'b0, 16'h0000);
    repeat (8) pulse_cycle(1'b1, 1'b0);
    check("zero count limits only", 16'h0001, {11'h000, rfault[0], cause[2:0], ccl[0]});
  endtask
  // sums stay under the slow threshold so only the fast path can trip
  task automatic t_fast();
    flim[15:0] = 16'h0032;
    host.write_word(8'hEB, 1'b0, 16'h0000);
    sums[15:0] = 16'h0064;
    tick(5);
    check("fast immediate", 16'h0001, {15'h0000, cause[3]});
    sums = '0;
    tick(3);
    clear_faults();
    host.write_word(8'hEB, 1'b0, 16'h0003);
    sums[15:0] = 16'h0064;
    tick(12);
    check("fast delay early", 16'h0000, {15'h0000, cause[3]});
    sums = '0;
    tick(4);
    sums[15:0] = 16'h0064;
    tick(12);
    check("fast delay restarted", 16'h0000, {15'h0000, cause[3]});
    tick(20);
    check("fast delay expired", 16'h0001, {15'h0000, cause[3]});
    sums = '0;
    flim = {2{16'h7FFF}};
    tick(3);
    clear_faults();
  endtask
  task automatic t_slow();
    scfg[15:0] = 16'h0001;
    host.write_word(8'hEA, 1'b0, 16'h0000);
    sums[15:0] = 16'h0064;
    tick(2000);
    check("slow disabled", 16'h0000, {15'h0000, cause[2]});
    host.write_word(8'hEA, 1'b0, 16'h0032);
    tick(1500);
    check("slow delay early", 16'h0000, {15'h0000, cause[2]});
    tick(300);
    check("slow fault", 16'h0001, {15'h0000, cause[2]});
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_resets();
    t_write_back();
    t_lanes();
    t_scale();
    t_peak();
    t_fast();
    t_slow();
    print_verdict();
  end
endmodule
